// ==== bcph_pkg.sv ====
// bridge control and express capability header: shared constants
// assumes a 32-bit apb slave with byte addressing, 12 address bits
package bcph_pkg;

   // ---------------------------------------------------------------
   // register indices and byte addresses (index times four)
   // ---------------------------------------------------------------
   localparam logic [9:0]  IDX_INTR_PIN  = 10'h03D;
   localparam logic [9:0]  IDX_BRIDGE_CONTROL      = 10'h03E;
   localparam logic [9:0]  IDX_CAP       = 10'h040;
   localparam logic [11:0] ADDR_INTR_PIN = {IDX_INTR_PIN, 2'b00};
   localparam logic [11:0] ADDR_BRIDGE_CONTROL     = {IDX_BRIDGE_CONTROL, 2'b00};
   localparam logic [11:0] ADDR_CAP      = {IDX_CAP, 2'b00};
   localparam logic [11:0] ADDR_LOCK     = 12'h200;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BRIDGE_CONTROL_PERR  = 0;
   localparam int BRIDGE_CONTROL_SERR  = 1;
   localparam int BRIDGE_CONTROL_ISA   = 2;
   localparam int BRIDGE_CONTROL_VGA   = 3;
   localparam int BRIDGE_CONTROL_VGA16 = 4;
   localparam int BRIDGE_CONTROL_SRST  = 6;
   localparam int CAP_SLOT   = 24;
   localparam int LOCK_BIT   = 0;
   localparam int LOCK_UP    = 1;

   // ---------------------------------------------------------------
   // reset and fixed values
   // ---------------------------------------------------------------
   localparam logic [7:0]  INTR_PIN_RST = 8'h00;
   localparam logic [15:0] BRIDGE_CONTROL_RST     = 16'h0000;
   localparam logic [15:0] BRIDGE_CONTROL_WMASK   = 16'h005F;
   localparam logic [7:0]  CAPABILITY_IDENTIFIER_VAL    = 8'h10;
   localparam logic [7:0]  NXT_PTR_RST  = 8'hC0;
   localparam logic [3:0]  CAP_VER_RST  = 4'h2;
   localparam logic [3:0]  TYPE_UP      = 4'h5;
   localparam logic [3:0]  TYPE_DOWN    = 4'h6;
   localparam logic [4:0]  IMN_VAL      = 5'h00;

   // ---------------------------------------------------------------
   // interrupt pin codes and address decode limits
   // ---------------------------------------------------------------
   localparam logic [7:0]  PIN_NONE = 8'h00;
   localparam logic [7:0]  PIN_INTD = 8'h04;
   localparam logic [31:0] ISA_TOP  = 32'h0000FFFF;
   localparam logic [9:0]  VGA_IO_A_LO = 10'h3B0;
   localparam logic [9:0]  VGA_IO_A_HI = 10'h3BB;
   localparam logic [9:0]  VGA_IO_B_LO = 10'h3C0;
   localparam logic [9:0]  VGA_IO_B_HI = 10'h3DF;
   localparam logic [31:0] VGA_MEM_LO  = 32'h000A0000;
   localparam logic [31:0] VGA_MEM_HI  = 32'h000BFFFF;

   typedef enum logic [1:0] {
      SEV_COR   = 2'h0,
      SEV_NF    = 2'h1,
      SEV_FATAL = 2'h2
   } bcph_sev_t;

   typedef enum logic [1:0] {
      APB_IDLE = 2'h1,
      APB_ACK  = 2'h2
   } bcph_apb_t;

   // byte-lane merge of a write into a word
   function automatic logic [31:0] bcph_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

// ==== bcph_route.sv ====
// bridge control: i/o and vga address routing decode
// assumes the i/o window base and limit come from outside registers
`timescale 1ns/1ns
module bcph_route import bcph_pkg::*; (
   input  wire logic        is_mem,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] win_base,
   input  wire logic [31:0] win_limit,
   input  wire logic        isa_en,
   input  wire logic        vga_en,
   input  wire logic        vga16,
   output logic             fwd_down,
   output logic             fwd_up,
   output logic             fwd_vga
);

   function automatic logic in_range(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   logic in_win;
   logic isa_zone;
   logic vga_io;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   always_comb begin
      in_win   = in_range(addr, win_base, win_limit);
      isa_zone = (addr <= ISA_TOP) && (addr[9:8] != 2'b00);
      vga_io   = in_range({22'h0, addr[9:0]}, {22'h0, VGA_IO_A_LO},
                          {22'h0, VGA_IO_A_HI})
              || in_range({22'h0, addr[9:0]}, {22'h0, VGA_IO_B_LO},
                          {22'h0, VGA_IO_B_HI});
      // upper bits only count in wide decode
      if (vga16 && (addr[31:10] != 22'h0)) begin
         vga_io = 1'b0;
      end
      fwd_up   = !is_mem && in_win && isa_en && isa_zone;
      fwd_down = !is_mem && in_win && !fwd_up;
      // width select only matters behind the enable
      fwd_vga  = vga_en && (is_mem ? in_range(addr, VGA_MEM_LO, VGA_MEM_HI)
                                   : vga_io);
   end

endmodule

// ==== bcph_err_gate.sv ====
// bridge control: gate for error messages from the secondary side
// assumes command and device-control enables come from other registers
`timescale 1ns/1ns
module bcph_err_gate import bcph_pkg::*; (
   input  wire logic      err_valid,
   input  wire bcph_sev_t err_sev,
   input  wire logic      serr_fwd_en,
   input  wire logic      cmd_serr_en,
   input  wire logic      dev_cor_en,
   input  wire logic      dev_nf_en,
   input  wire logic      dev_fatal_en,
   output logic           fwd
);

   logic sev_en;

   always_comb begin
      case (err_sev)
         SEV_COR:   sev_en = dev_cor_en;
         SEV_NF:    sev_en = dev_nf_en;
         SEV_FATAL: sev_en = dev_fatal_en;
         default:   sev_en = 1'b0;
      endcase
      fwd = err_valid && serr_fwd_en && (cmd_serr_en || sev_en);
   end

endmodule

// ==== bcph_regs.sv ====
// bridge control and express capability header register bank
// assumes an apb master on pclk and a port-type strap held stable
//
// Function
// - interrupt pin 0 means none, 1 to 4 select INTA to INTD
// - interrupt pin resets to zero
// - error forward enable passes secondary error messages to primary
// - forwarded errors also need command or device control enables
// - isa routing off: whole i/o window goes downstream
// - isa routing on: top 768 bytes per 1-KB below 64 KB go upstream
// - vga routing enable forwards vga addresses downstream
// - vga width select matters only while vga routing is enabled
// - width select 0 decodes 10 bits, 1 decodes all 32 address bits
// - setting the reset bit drives a secondary bus reset
// - parity error response bit is plain read-write, resets zero
// - capability identifier reads 0x10
// - next pointer is lockable writable, resets to 0xC0
// - capability version is lockable writable, resets to 0x2
// - port type reads 0x5 upstream, 0x6 downstream
// - slot bit resets zero and stays zero on the upstream port
// - interrupt message number reads zero
`timescale 1ns/1ns
module bcph_regs import bcph_pkg::*; (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        upstream_port,
   input  wire logic [31:0] io_win_base,
   input  wire logic [31:0] io_win_limit,
   input  wire logic        req_valid,
   input  wire logic        req_is_mem,
   input  wire logic [31:0] req_addr,
   output logic             route_valid,
   output logic             route_down,
   output logic             route_up,
   output logic             route_vga,
   input  wire logic        err_in_valid,
   input  wire bcph_sev_t   err_in_sev,
   input  wire logic        cmd_serr_enable,
   input  wire logic        devctl_cor_enable,
   input  wire logic        devctl_nonfatal_enable,
   input  wire logic        devctl_fatal_enable,
   output logic             err_out_valid,
   output bcph_sev_t        err_out_sev,
   output logic             sec_reset_upstream,
   output logic             sec_reset_downstream,
   output logic      [3:0]  intx_select
);

   bcph_apb_t   state;
   logic [7:0]  intr_pin;
   logic [15:0] bridge_control;
   logic [7:0]  nxt_ptr;
   logic [3:0]  cap_ver;
   logic        slot;
   logic        lock;
   logic        upstream_q;
   logic        strap_taken;
   logic [3:0]  port_type;
   logic [31:0] cap_word;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic [31:0] pin_merged;
   logic [31:0] bridge_control_merged;
   logic [31:0] cap_merged;
   logic [31:0] lock_merged;
   logic        setup;
   logic        wr_en;
   logic        dec_down;
   logic        dec_up;
   logic        dec_vga;
   logic        err_fwd;

   // ---------------------------------------------------------------
   // apb handshake
   // ---------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state  <= APB_IDLE;
         pready <= 1'b0;
      end else begin
         case (state)
            APB_IDLE: begin
               if (setup) begin
                  state  <= APB_ACK;
                  pready <= 1'b1;
               end
            end
            APB_ACK: begin
               state  <= APB_IDLE;
               pready <= 1'b0;
            end
            default: begin
               state  <= APB_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // port type strap, caught once after reset release
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upstream_q  <= 1'b0;
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         upstream_q  <= upstream_port;
         strap_taken <= 1'b1;
      end
   end

   assign port_type = upstream_q ? TYPE_UP : TYPE_DOWN;
   assign cap_word  = {2'b00, IMN_VAL, slot, port_type,
                       cap_ver, nxt_ptr, CAPABILITY_IDENTIFIER_VAL};

   // ---------------------------------------------------------------
   // write merge
   // ---------------------------------------------------------------
   always_comb begin
      pin_merged  = bcph_merge({24'h0, intr_pin}, pwdata, pstrb);
      bridge_control_merged = bcph_merge({16'h0, bridge_control}, pwdata, pstrb);
      cap_merged  = bcph_merge(cap_word, pwdata, pstrb);
      lock_merged = bcph_merge({31'h0, lock}, pwdata, pstrb);
   end

   // ---------------------------------------------------------------
   // interrupt pin select
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         intr_pin <= INTR_PIN_RST;
      end else if (wr_en && paddr == ADDR_INTR_PIN && !lock) begin
         intr_pin <= pin_merged[7:0];
      end
   end

   // legacy line chosen by the pin code, nothing above INTD
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         intx_select <= 4'h0;
      end else if (intr_pin == PIN_NONE || intr_pin > PIN_INTD) begin
         intx_select <= 4'h0;
      end else begin
         intx_select <= 4'h1 << (intr_pin[1:0] - 2'd1);
      end
   end

   // ---------------------------------------------------------------
   // bridge control
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_control <= BRIDGE_CONTROL_RST;
      end else if (wr_en && paddr == ADDR_BRIDGE_CONTROL) begin
         bridge_control <= bridge_control_merged[15:0] & BRIDGE_CONTROL_WMASK;
      end
   end

   // secondary bus reset held while the trigger bit is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_reset_upstream   <= 1'b0;
         sec_reset_downstream <= 1'b0;
      end else begin
         sec_reset_upstream   <= bridge_control[BRIDGE_CONTROL_SRST] && upstream_q;
         sec_reset_downstream <= bridge_control[BRIDGE_CONTROL_SRST] && !upstream_q;
      end
   end

   // ---------------------------------------------------------------
   // capability header and lock
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nxt_ptr <= NXT_PTR_RST;
         cap_ver <= CAP_VER_RST;
         slot    <= 1'b0;
      end else begin
         if (wr_en && paddr == ADDR_CAP && !lock) begin
            nxt_ptr <= cap_merged[15:8];
            cap_ver <= cap_merged[19:16];
            slot    <= cap_merged[CAP_SLOT] && !upstream_q;
         end
         if (upstream_q) begin
            slot <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock <= 1'b0;
      end else if (wr_en && paddr == ADDR_LOCK) begin
         lock <= lock_merged[LOCK_BIT];
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb begin
      next_prdata  = 32'h0;
      next_pslverr = 1'b0;
      case (paddr)
         ADDR_INTR_PIN: next_prdata = {24'h0, intr_pin};
         ADDR_BRIDGE_CONTROL:     next_prdata = {16'h0, bridge_control};
         ADDR_CAP:      next_prdata = cap_word;
         ADDR_LOCK:     next_prdata = {30'h0, upstream_q, lock};
         default:       next_pslverr = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h0 : next_prdata;
         pslverr <= next_pslverr;
      end else begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // address routing
   // ---------------------------------------------------------------
   bcph_route u_route (
      .is_mem    (req_is_mem),
      .addr      (req_addr),
      .win_base  (io_win_base),
      .win_limit (io_win_limit),
      .isa_en    (bridge_control[BRIDGE_CONTROL_ISA]),
      .vga_en    (bridge_control[BRIDGE_CONTROL_VGA]),
      .vga16     (bridge_control[BRIDGE_CONTROL_VGA16]),
      .fwd_down  (dec_down),
      .fwd_up    (dec_up),
      .fwd_vga   (dec_vga)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_valid <= 1'b0;
         route_down  <= 1'b0;
         route_up    <= 1'b0;
         route_vga   <= 1'b0;
      end else begin
         route_valid <= req_valid;
         route_down  <= req_valid && dec_down;
         route_up    <= req_valid && dec_up;
         route_vga   <= req_valid && dec_vga;
      end
   end

   // ---------------------------------------------------------------
   // error forwarding
   // ---------------------------------------------------------------
   bcph_err_gate u_err (
      .err_valid    (err_in_valid),
      .err_sev      (err_in_sev),
      .serr_fwd_en  (bridge_control[BRIDGE_CONTROL_SERR]),
      .cmd_serr_en  (cmd_serr_enable),
      .dev_cor_en   (devctl_cor_enable),
      .dev_nf_en    (devctl_nonfatal_enable),
      .dev_fatal_en (devctl_fatal_enable),
      .fwd          (err_fwd)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_out_valid <= 1'b0;
         err_out_sev   <= SEV_COR;
      end else begin
         err_out_valid <= err_fwd;
         err_out_sev   <= err_in_sev;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_answer_a: assert property (
      setup && state == APB_IDLE |=> pready ##1 !pready)
      else $error("apb access phase not answered in one cycle");

   intx_map_a: assert property (
      ##1 (intr_pin == 8'h01 && $stable(intr_pin))
      |=> intx_select == 4'b0001)
      else $error("pin code one does not select the first line");

   err_block_a: assert property (
      err_in_valid && !bridge_control[BRIDGE_CONTROL_SERR] |=> !err_out_valid)
      else $error("error forwarded with forwarding disabled");

   err_gate_a: assert property (
      err_in_valid && bridge_control[BRIDGE_CONTROL_SERR] && !cmd_serr_enable
      && !devctl_cor_enable && !devctl_nonfatal_enable
      && !devctl_fatal_enable |=> !err_out_valid)
      else $error("error forwarded without reporting enabled");

   isa_down_a: assert property (
      req_valid && !req_is_mem && !bridge_control[BRIDGE_CONTROL_ISA]
      && req_addr >= io_win_base && req_addr <= io_win_limit
      |=> route_down && !route_up)
      else $error("window address not sent downstream");

   isa_up_a: assert property (
      req_valid && !req_is_mem && bridge_control[BRIDGE_CONTROL_ISA]
      && req_addr >= io_win_base && req_addr <= io_win_limit
      && req_addr[31:16] == 16'h0 && req_addr[9:8] != 2'b00
      |=> route_up && !route_down)
      else $error("isa address not sent upstream");

   vga_block_a: assert property (
      req_valid && !bridge_control[BRIDGE_CONTROL_VGA] |=> !route_vga)
      else $error("vga address forwarded while blocked");

   vga_alias_a: assert property (
      req_valid && !req_is_mem && bridge_control[BRIDGE_CONTROL_VGA] && !bridge_control[BRIDGE_CONTROL_VGA16]
      && req_addr[9:0] == 10'h3C0 |=> route_vga)
      else $error("aliased vga address not forwarded");

   vga_wide_a: assert property (
      req_valid && !req_is_mem && bridge_control[BRIDGE_CONTROL_VGA16]
      && req_addr[15:10] != 6'h0 |=> !route_vga)
      else $error("16-bit vga decode aliased");

   sbr_drive_a: assert property (
      $rose(bridge_control[BRIDGE_CONTROL_SRST]) |=> (sec_reset_upstream
      || sec_reset_downstream) && $past(bridge_control[BRIDGE_CONTROL_SRST]))
      else $error("secondary bus reset not driven");

   cap_fixed_a: assert property (
      setup && !pwrite && paddr == ADDR_CAP |=> prdata[7:0] == 8'h10
      && prdata[31:25] == 7'h0)
      else $error("capability id or fixed bits wrong");

   bridge_control_resv_a: assert property (
      setup && !pwrite && paddr == ADDR_BRIDGE_CONTROL
      |=> prdata[15:7] == 9'h0 && !prdata[5])
      else $error("reserved control bits read nonzero");

   lock_hold_a: assert property (
      wr_en && lock && paddr == ADDR_CAP
      |=> $stable(nxt_ptr) && $stable(cap_ver))
      else $error("locked capability field changed");

   slot_up_a: assert property (
      upstream_q |=> !slot)
      else $error("slot bit set on upstream port");

   isa_up_c: cover property (req_valid ##1 route_up);
   vga_fwd_c: cover property (req_valid ##1 route_vga);
   err_fwd_c: cover property (err_in_valid ##1 err_out_valid);
   sbr_c: cover property ($rose(sec_reset_downstream));

endmodule

// ==== bcph_host.sv ====
// host configuration software model: apb master transfers
// assumes pclk from the bench and a zero or more wait slave
`timescale 1ns/1ns
module bcph_host (
   input  wire logic        pclk,
   output logic      [11:0] paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      {paddr, psel, penable, pwrite, pwdata, pstrb} = '0;
   end

   // ------------------------------------------------------------
   // one transfer, setup on the next edge, held until pready
   // ------------------------------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      @(posedge pclk);
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb  <= 4'hF;
      psel   <= 1'h1;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
endmodule

// ==== bcph_regs_test.sv ====
// bench for the bridge control and capability register bank
// assumes bcph_host as apb master; side inputs driven here
`timescale 1ns/1ns
module bcph_regs_test import bcph_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, req_addr, rd;
   logic [3:0]  pstrb, intx_select;
   logic        upstream_port, req_valid, req_is_mem, er;
   logic        route_valid, route_down, route_up, route_vga;
   logic        err_in_valid, devctl_fatal_enable, err_out_valid;
   logic        cmd_serr_enable;
   logic        sec_reset_upstream, sec_reset_downstream;
   bcph_sev_t   err_in_sev, err_out_sev;
   int          err_count, tests_run, cycles;
   typedef struct {
      logic [11:0] a;
      logic        w;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } bcph_row_t;
   bcph_row_t rows [13] = '{
      '{ADDR_INTR_PIN, 1'h0, 32'h0, 32'h0, 1'h0},
      '{ADDR_BRIDGE_CONTROL, 1'h0, 32'h0, 32'h0, 1'h0},
      '{ADDR_CAP, 1'h0, 32'h0, 32'h0062C010, 1'h0},
      '{ADDR_INTR_PIN, 1'h1, 32'h1, 32'h0, 1'h0},
      '{ADDR_INTR_PIN, 1'h0, 32'h0, 32'h1, 1'h0},
      '{ADDR_BRIDGE_CONTROL, 1'h1, 32'hFFBF, 32'h0, 1'h0},
      '{ADDR_BRIDGE_CONTROL, 1'h0, 32'h0, 32'h1F, 1'h0},
      '{ADDR_CAP, 1'h1, 32'hFFFFFFFF, 32'h0, 1'h0},
      '{ADDR_CAP, 1'h0, 32'h0, 32'h016FFF10, 1'h0},
      '{ADDR_LOCK, 1'h1, 32'h1, 32'h0, 1'h0},
      '{ADDR_CAP, 1'h1, 32'h0, 32'h0, 1'h0},
      '{ADDR_CAP, 1'h0, 32'h0, 32'h016FFF10, 1'h0},
      '{12'h300, 1'h0, 32'h0, 32'h0, 1'h1}};

   bcph_regs u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .upstream_port,
      .io_win_base(32'h0), .io_win_limit(32'h0001FFFF), .req_valid,
      .req_is_mem, .req_addr, .route_valid, .route_down, .route_up,
      .route_vga, .err_in_valid, .err_in_sev, .cmd_serr_enable,
      .devctl_cor_enable(1'h0), .devctl_nonfatal_enable(1'h0),
      .devctl_fatal_enable, .err_out_valid, .err_out_sev,
      .sec_reset_upstream, .sec_reset_downstream, .intx_select);
   bcph_host u_host (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata,
      .pstrb, .prdata, .pready, .pslverr);

   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         final_report();
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] x,
                      input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         $display("[FAIL] %s expected %h seen %h", n, x, g);
         err_count++;
      end
   endtask

   task automatic acc(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [31:0] x);
      u_host.xfer(w, a, d, rd, er);
      if (!w) chk("rdata", x, rd);
   endtask

   task automatic do_reset(input logic u);
      presetn       <= 1'h0;
      upstream_port <= u;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
   endtask

   // one request and one fatal/cor message, checked a cycle later
   task automatic rt(input logic [15:0] b, input logic [31:0] a,
                     input logic m, input bcph_sev_t s,
                     input logic [3:0] x);
      acc(1'h1, ADDR_BRIDGE_CONTROL, {16'h0, b}, 32'h0);
      @(posedge pclk);
      req_valid    <= 1'h1;
      err_in_valid <= 1'h1;
      req_addr     <= a;
      req_is_mem   <= m;
      err_in_sev   <= s;
      @(posedge pclk);
      req_valid    <= 1'h0;
      err_in_valid <= 1'h0;
      #1;
      chk("route", {27'h0, 1'h1, x}, {27'h0, route_valid, route_down,
          route_up, route_vga, err_out_valid});
      chk("sev", {30'h0, s}, {30'h0, err_out_sev});
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {err_count, tests_run, cycles} = '0;
      {req_valid, req_is_mem, req_addr, err_in_valid} <= '0;
      devctl_fatal_enable <= 1'h1;
      cmd_serr_enable     <= 1'h0;
      err_in_sev          <= SEV_FATAL;
      do_reset(1'h0);
      foreach (rows[i]) begin
         u_host.xfer(rows[i].w, rows[i].a, rows[i].d, rd, er);
         chk("slverr", {31'h0, rows[i].e}, {31'h0, er});
         if (!rows[i].w) chk("rdata", rows[i].x, rd);
      end
      chk("intx", 32'h1, {28'h0, intx_select});
      $display("register table done");
      rt(16'h04, 32'h100, 1'h0, SEV_FATAL, 4'h4);
      rt(16'h04, 32'h050, 1'h0, SEV_FATAL, 4'h8);
      rt(16'h04, 32'h10100, 1'h0, SEV_FATAL, 4'h8);
      rt(16'h00, 32'h100, 1'h0, SEV_FATAL, 4'h8);
      rt(16'h00, 32'h3C0, 1'h0, SEV_FATAL, 4'h8);
      rt(16'h10, 32'h3C0, 1'h0, SEV_FATAL, 4'h8);
      rt(16'h08, 32'h13C0, 1'h0, SEV_FATAL, 4'hA);
      rt(16'h18, 32'h13C0, 1'h0, SEV_FATAL, 4'h8);
      rt(16'h18, 32'h3C0, 1'h0, SEV_FATAL, 4'hA);
      rt(16'h0A, 32'h3C0, 1'h0, SEV_FATAL, 4'hB);
      rt(16'h0A, 32'h3C0, 1'h0, SEV_COR, 4'hA);
      cmd_serr_enable <= 1'h1;
      rt(16'h0A, 32'h3C0, 1'h0, SEV_COR, 4'hB);
      cmd_serr_enable <= 1'h0;
      rt(16'h08, 32'hA0000, 1'h1, SEV_FATAL, 4'h2);
      $display("routing and error gating done");
      acc(1'h1, ADDR_BRIDGE_CONTROL, 32'h40, 32'h0);
      @(posedge pclk);
      #1;
      chk("srst down", 32'h1, {30'h0, sec_reset_upstream,
          sec_reset_downstream});
      acc(1'h1, ADDR_BRIDGE_CONTROL, 32'h0, 32'h0);
      do_reset(1'h1);
      acc(1'h0, ADDR_INTR_PIN, 32'h0, 32'h0);
      acc(1'h0, ADDR_CAP, 32'h0, 32'h0052C010);
      acc(1'h1, ADDR_CAP, 32'hFFFFFFFF, 32'h0);
      acc(1'h0, ADDR_CAP, 32'h0, 32'h005FFF10);
      acc(1'h1, ADDR_BRIDGE_CONTROL, 32'h40, 32'h0);
      @(posedge pclk);
      #1;
      chk("srst up", 32'h2, {30'h0, sec_reset_upstream,
          sec_reset_downstream});
      $display("upstream port done");
      final_report();
   end
endmodule
